// *** verilog/pstn_path_setup_fsm.sv ***
// Functional notes
// [RULE1] Exchange acks accepted setup, enters active
// [RULE2] ESTABLISH ACK: stop timer, go active transparent
// [RULE3] Exchange notifies on repeated ESTABLISH
// [RULE4] Exchange may start own path meanwhile
// [RULE5] First timer expiry: resend, start repeat timer
// [RULE6] Repeat timer expiry: resend, restart, forever
// [RULE7] Ignore line signals except release
// [RULE8] Release moves to abort request
// [RULE9] Abort request: timer expiry goes null
// [RULE10] Abort: ignore signals, store line condition
// [RULE11] Abort plus ESTABLISH ACK: send DISCONNECT
// [RULE12] Abort plus seizure: optional ack, reinitiate
// [RULE13] Exchange starts path from null
// [RULE14] Null plus ESTABLISH: signal, ack, active
// [RULE15] Exchange discards accept in null
// [RULE16] Exchange goes active on ack
// [RULE17] Exchange teardown sends DISCONNECT
// [RULE18] Exchange retries once then errors
// [RULE19] Port priority selects collision winner
// [RULE20] Originating priority: keep state on ESTABLISH
// [RULE21] Exchange notifies and later accepts
// [RULE22] Terminating priority: ack, transparent, active
// [RULE23] Null plus seizure: establish, timer, interrupt
// [RULE24] DISCONNECT messages always go to disconnect
// [RULE25] Timers count ticks, pulse on expiry
`timescale 1ns/1ps
`include "path_setup_params.svh"
module pstn_path_setup_fsm
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // Configuration
  input wire logic terminatingPriority,
  input wire logic autonomousAck,
  input wire logic ringOnEstablish,
  // User port events, one-cycle pulses
  input wire logic lineSeizureEvent,
  input wire logic lineReleaseEvent,
  input wire logic lineSignallingEvent,
  input wire logic lineConditionEvent,
  // Inbound message from the exchange
  input wire path_setup_pkg::msg_code_t rxMsg,
  // Outbound messages, one-cycle pulses
  output logic txEstablish,
  output logic txEstablishAck,
  output logic txDisconnect,
  // User port and bearer
  output logic seizureAck,
  output logic lineSignalOut,
  output logic bearerTransparent,
  output logic seqInit,
  output logic disconnectHandoff,
  output logic lineConditionSaved,
  output path_setup_pkg::path_state_t pathState
);
  import path_setup_pkg::*;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  timer_ctl_if firstCtl ();
  timer_ctl_if repeatCtl ();
  establish_timer #(.TICKS(`FIRST_TIMER_TICKS)) firstTimer (
    .clk(clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .ctl(firstCtl)
  );
  establish_timer #(.TICKS(`REPEAT_TIMER_TICKS)) repeatTimer (
    .clk(clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .ctl(repeatCtl)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  logic gotEstablish; // ESTABLISH received
  logic gotAck; // ESTABLISH ACK received
  logic gotDisc; // DISCONNECT or DISCONNECT COMPLETE
  logic anyExpire; // Either timer expired
  assign gotEstablish = (rxMsg == `MSG_ESTABLISH);
  assign gotAck = (rxMsg == `MSG_ESTABLISH_ACK);
  assign gotDisc = (rxMsg == `MSG_DISCONNECT) || (rxMsg == `MSG_DISCONNECT_COMPLETE);
  assign anyExpire = firstCtl.expire | repeatCtl.expire;

  // ----------------------------------------
  // Next state and actions
  // ----------------------------------------
  path_state_t next_state;
  logic next_tx; // Send ESTABLISH
  logic next_ack; // Send ESTABLISH ACK
  logic next_disc; // Send DISCONNECT
  logic startFirst;
  logic startRepeat;
  logic stopTimers;
  // One event served per cycle; a message outranks user events
  always_comb
  begin
    next_state = pathState;
    next_tx = 1'b0;
    next_ack = 1'b0;
    next_disc = 1'b0;
    startFirst = 1'b0;
    startRepeat = 1'b0;
    stopTimers = 1'b0;
    if (gotDisc)
    begin
      // Never unexpected; hand over to disconnect handling
      stopTimers = 1'b1; // RULE24
      next_state = PATH_DISC; // RULE24
    end
    else
    begin
      case (pathState)
        PATH_NULL:
        begin
          if (gotEstablish)
          begin
            next_ack = 1'b1; // RULE14
            next_state = PATH_ACTIVE; // RULE14
          end
          else if (lineSeizureEvent)
          begin
            next_tx = 1'b1; // RULE23
            startFirst = 1'b1; // RULE23
            next_state = PATH_BY_ACCESS; // RULE23
          end
        end
        PATH_BY_ACCESS, PATH_ABORT_REQ:
        begin
          if (gotAck && pathState == PATH_BY_ACCESS)
          begin
            stopTimers = 1'b1; // RULE2
            next_state = PATH_ACTIVE; // RULE2
          end
          else if (gotAck)
          begin
            stopTimers = 1'b1; // RULE11
            next_disc = 1'b1; // RULE11
            next_state = PATH_DISC; // RULE11
          end
          else if (gotEstablish && terminatingPriority) // RULE19
          begin
            // Collision lost to the exchange
            stopTimers = 1'b1; // RULE22
            next_ack = 1'b1; // RULE22
            next_state = PATH_ACTIVE; // RULE22
          end
          else if (gotEstablish)
            next_state = pathState; // RULE20
          else if (pathState == PATH_ABORT_REQ)
          begin
            if (anyExpire)
              next_state = PATH_NULL; // RULE9
            else if (lineSeizureEvent)
              next_state = PATH_BY_ACCESS; // RULE12
          end
          else if (firstCtl.expire || repeatCtl.expire)
          begin
            // Timers keep running unbounded; no retry limit
            next_tx = 1'b1; // RULE5 RULE6
            startRepeat = 1'b1; // RULE5 RULE6
          end
          else if (lineReleaseEvent)
            next_state = PATH_ABORT_REQ; // RULE8
          // Other line signalling is dropped here; it never moves the state
          else if (lineSignallingEvent)
            next_state = pathState; // RULE7
        end
        PATH_ACTIVE, PATH_DISC:
          next_state = pathState;
        default:
          next_state = PATH_NULL;
      endcase
    end
  end

  // Timer control wiring
  assign firstCtl.start = startFirst;
  assign firstCtl.stop = stopTimers;
  assign repeatCtl.start = startRepeat;
  assign repeatCtl.stop = stopTimers | startFirst;

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Path state updates
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pathState <= PATH_NULL;
    else if (clkEnable)
      pathState <= next_state;
  end

  // ----------------------------------------
  // Message outputs
  // ----------------------------------------
  // Registered one-cycle message strobes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txEstablish <= 1'b0;
      txEstablishAck <= 1'b0;
      txDisconnect <= 1'b0;
      seqInit <= 1'b0;
      disconnectHandoff <= 1'b0;
    end
    else if (clkEnable)
    begin
      txEstablish <= next_tx;
      txEstablishAck <= next_ack;
      txDisconnect <= next_disc;
      // Sequence numbers reset whenever the path goes active
      seqInit <= (next_state == PATH_ACTIVE) && (pathState != PATH_ACTIVE); // RULE2
      disconnectHandoff <= (next_state == PATH_DISC) && (pathState != PATH_DISC);
    end
  end

  // ----------------------------------------
  // User port and bearer
  // ----------------------------------------
  // Acknowledges, ring signal and bearer state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seizureAck <= 1'b0;
      lineSignalOut <= 1'b0;
      bearerTransparent <= 1'b1;
    end
    else if (clkEnable)
    begin
      // Ack only when configured
      seizureAck <= autonomousAck && lineSeizureEvent && !gotDisc && !gotEstablish &&
        !gotAck && !anyExpire && (pathState == PATH_ABORT_REQ); // RULE12
      lineSignalOut <= ringOnEstablish && !gotDisc && gotEstablish &&
        (pathState == PATH_NULL); // RULE14
      if (next_state == PATH_BY_ACCESS && pathState == PATH_NULL)
        bearerTransparent <= 1'b0; // RULE23
      else if (next_state == PATH_ACTIVE)
        bearerTransparent <= 1'b1; // RULE2 RULE22
    end
  end

  // Saved line condition, replayed later by the line procedure
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lineConditionSaved <= 1'b0;
    else if (clkEnable)
    begin
      if (pathState == PATH_ABORT_REQ && lineConditionEvent)
        lineConditionSaved <= 1'b1; // RULE10
      else if (pathState == PATH_NULL)
        lineConditionSaved <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ack_goes_active: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_BY_ACCESS && rxMsg == `MSG_ESTABLISH_ACK
    |=> pathState == PATH_ACTIVE && seqInit) else $error("ack did not activate path"); // RULE2
  a_first_expiry_resend: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_BY_ACCESS && rxMsg == `MSG_NONE && firstCtl.expire
    |=> txEstablish && pathState == PATH_BY_ACCESS) else $error("no resend on expiry"); // RULE5
  a_repeat_expiry_resend: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_BY_ACCESS && rxMsg == `MSG_NONE && repeatCtl.expire
    |=> txEstablish) else $error("no resend on repeat expiry"); // RULE6
  a_signal_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_BY_ACCESS && rxMsg == `MSG_NONE && !anyExpire &&
    lineSignallingEvent && !lineReleaseEvent |=> pathState == PATH_BY_ACCESS)
    else $error("state left on signal"); // RULE7
  a_release_aborts: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_BY_ACCESS && rxMsg == `MSG_NONE && !anyExpire &&
    lineReleaseEvent |=> pathState == PATH_ABORT_REQ) else $error("release not aborted"); // RULE8
  a_abort_expiry_null: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_ABORT_REQ && rxMsg == `MSG_NONE && anyExpire
    |=> pathState == PATH_NULL) else $error("abort expiry not null"); // RULE9
  a_abort_ack_disc: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_ABORT_REQ && rxMsg == `MSG_ESTABLISH_ACK
    |=> txDisconnect && pathState == PATH_DISC) else $error("no disconnect on ack"); // RULE11
  a_null_establish: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_NULL && rxMsg == `MSG_ESTABLISH
    |=> txEstablishAck && pathState == PATH_ACTIVE) else $error("null establish"); // RULE14
  a_seizure_starts: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && pathState == PATH_NULL && rxMsg == `MSG_NONE && lineSeizureEvent
    |=> txEstablish && !bearerTransparent ##0 pathState == PATH_BY_ACCESS)
    else $error("seizure did not start path"); // RULE23
  a_collision_term: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && terminatingPriority && pathState == PATH_BY_ACCESS &&
    rxMsg == `MSG_ESTABLISH |=> txEstablishAck && bearerTransparent)
    else $error("collision not yielded"); // RULE22
  a_disc_handoff: assert property (@(posedge clk) disable iff (!reset_n)
    clkEnable && (rxMsg == `MSG_DISCONNECT || rxMsg == `MSG_DISCONNECT_COMPLETE)
    |=> pathState == PATH_DISC) else $error("disconnect not handed over"); // RULE24
endmodule // pstn_path_setup_fsm

// *** verilog/path_setup_params.svh ***
`ifndef PATH_SETUP_PARAMS_SVH
`define PATH_SETUP_PARAMS_SVH
// Timer tick counts in clock cycles
`define FIRST_TIMER_TICKS 16'h0010
`define REPEAT_TIMER_TICKS 16'h0008
`define TIMER_WIDTH 16
// Inbound message codes
`define MSG_NONE 3'h0
`define MSG_ESTABLISH 3'h1
`define MSG_ESTABLISH_ACK 3'h2
`define MSG_SIGNAL 3'h3
`define MSG_DISCONNECT 3'h4
`define MSG_DISCONNECT_COMPLETE 3'h5
`endif

// *** verilog/path_setup_pkg.sv ***
package path_setup_pkg;
  // Path states of the access network side
  typedef enum logic [2:0] {
    PATH_NULL,
    PATH_BY_ACCESS,
    PATH_ABORT_REQ,
    PATH_ACTIVE,
    PATH_DISC
  } path_state_t;
  // Message code type
  typedef logic [2:0] msg_code_t;
endpackage

// *** verilog/timer_ctl_if.sv ***
`timescale 1ns/1ps
// Control and expiry of one establish timer
interface timer_ctl_if;
  logic start;
  logic stop;
  logic expire;
  modport owner (output start, output stop, input expire);
  modport timer (input start, input stop, output expire);
endinterface

// *** verilog/establish_timer.sv ***
`timescale 1ns/1ps
`include "path_setup_params.svh"
// Single establish timer: counts ticks, one-cycle expiry pulse
module establish_timer #(
  parameter logic [`TIMER_WIDTH-1:0] TICKS = `FIRST_TIMER_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // Control
  timer_ctl_if.timer ctl
);
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [`TIMER_WIDTH-1:0] count; // Remaining ticks
  logic running; // Timer armed
  // Count down; start wins over stop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      running <= 1'b0;
      ctl.expire <= 1'b0;
    end
    else if (clkEnable)
    begin
      ctl.expire <= 1'b0;
      if (ctl.start)
      begin
        // Restart from full count
        count <= TICKS;
        running <= 1'b1;
      end
      else if (ctl.stop)
        running <= 1'b0;
      else if (running)
      begin
        if (count <= 16'h0001)
        begin
          // Single pulse, then idle until restarted
          running <= 1'b0;
          ctl.expire <= 1'b1; // RULE25
        end
        else
          count <= count - 16'h0001;
      end
    end
  end
  // Expiry is a single pulse
  a_expire_single: assert property (@(posedge clk) disable iff (!reset_n)
    ctl.expire |=> !ctl.expire) else $error("expiry pulse longer than one cycle"); // RULE25
endmodule // establish_timer

// *** dv/exchange_model.sv ***
`timescale 1ns/1ps
`include "path_setup_params.svh"
// Behavioural exchange side, driven by national commands from the bench
module exchange_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // National commands: 1 setup, 2 accept, 3 teardown, 4 raw SIGNAL
  input wire logic [2:0] cmd,
  // Messages from the port
  input wire logic txEstablish,
  input wire logic txEstablishAck,
  // Messages to the port, notice to national side
  output path_setup_pkg::msg_code_t rxMsg,
  output logic arrivalNotice
);
  import path_setup_pkg::*;
  // Exchange view of the path
  typedef enum logic [2:0] {X_NULL, X_BY_AN, X_BY_LE, X_ACTIVE, X_DISC} xstate_t;
  xstate_t st; // Current state
  logic [7:0] leTimer; // Exchange first establish timer, longer than any test gap
  logic leRetried; // First expiry already spent
  // --------------------------------
  // Message engine
  // --------------------------------
  // One message per cycle; a message lasts one cycle so no stale code lingers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= X_NULL;
      leTimer <= 8'h40;
      leRetried <= 1'b0;
      rxMsg <= `MSG_NONE;
      arrivalNotice <= 1'h0;
    end
    else
    begin
      rxMsg <= (cmd == 3'h4) ? `MSG_SIGNAL : `MSG_NONE;
      arrivalNotice <= 1'h0;
      case (st)
        X_NULL:
          if (cmd == 3'h1)
          begin
            rxMsg <= `MSG_ESTABLISH;
            leTimer <= 8'h40;
            leRetried <= 1'b0;
            st <= X_BY_LE;
          end
          else if (txEstablish)
          begin
            arrivalNotice <= 1'h1;
            st <= X_BY_AN;
          end
        X_BY_AN:
          if (cmd == 3'h2)
          begin
            rxMsg <= `MSG_ESTABLISH_ACK;
            st <= X_ACTIVE;
          end
          else if (cmd == 3'h1)
          begin
            rxMsg <= `MSG_ESTABLISH;
            leTimer <= 8'h40;
            leRetried <= 1'b0;
            st <= X_BY_LE;
          end
          else if (txEstablish)
            arrivalNotice <= 1'h1;
        X_BY_LE:
          if (txEstablishAck)
            st <= X_ACTIVE;
          else if (cmd == 3'h2)
          begin
            rxMsg <= `MSG_ESTABLISH_ACK;
            st <= X_ACTIVE;
          end
          else if (cmd == 3'h3)
          begin
            rxMsg <= `MSG_DISCONNECT;
            st <= X_DISC;
          end
          else if (txEstablish)
            arrivalNotice <= 1'h1;
          else if (leTimer == 8'h01)
          begin
            // One resend, then give up with a teardown
            if (!leRetried)
            begin
              rxMsg <= `MSG_ESTABLISH;
              leTimer <= 8'h40;
              leRetried <= 1'b1;
            end
            else
            begin
              rxMsg <= `MSG_DISCONNECT;
              st <= X_DISC;
            end
          end
          else
            leTimer <= leTimer - 8'h01;
        default:
          st <= st; // Active and teardown wait for reset
      endcase
    end
  end
endmodule // exchange_model

// *** dv/pstn_path_setup_fsm_tb.sv ***
`timescale 1ns/1ps
module pstn_path_setup_fsm_tb;
  import path_setup_pkg::*;
  // --------------------------------
  // Signals
  // --------------------------------
  // Expected event word with care mask
  typedef struct packed {logic [11:0] v; logic [11:0] m;} note_t;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic clkEnable = 1'h1;
  logic terminatingPriority = 1'h0;
  logic autonomousAck = 1'h0;
  logic ringOnEstablish = 1'h0;
  logic [3:0] userEv = 4'h0; // Seizure, release, signalling, condition
  logic [2:0] exCmd = 3'h0; // Exchange command
  msg_code_t rxMsg;
  logic txEstablish, txEstablishAck, txDisconnect, seizureAck, lineSignalOut;
  logic bearerTransparent, seqInit, disconnectHandoff, lineConditionSaved;
  path_state_t pathState;
  logic [11:0] obs, prevObs; // State, levels, pulses
  note_t expQ[$];
  note_t n;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32318;
  int aa, i;
  pstn_path_setup_fsm dut (.clk(clk), .reset_n(reset_n), .clkEnable(clkEnable),
    .terminatingPriority(terminatingPriority), .autonomousAck(autonomousAck),
    .ringOnEstablish(ringOnEstablish), .lineSeizureEvent(userEv[0]),
    .lineReleaseEvent(userEv[1]), .lineSignallingEvent(userEv[2]),
    .lineConditionEvent(userEv[3]), .rxMsg(rxMsg), .txEstablish(txEstablish),
    .txEstablishAck(txEstablishAck), .txDisconnect(txDisconnect), .seizureAck(seizureAck),
    .lineSignalOut(lineSignalOut), .bearerTransparent(bearerTransparent),
    .seqInit(seqInit), .disconnectHandoff(disconnectHandoff),
    .lineConditionSaved(lineConditionSaved), .pathState(pathState));
  exchange_model peer (.clk(clk), .reset_n(reset_n), .cmd(exCmd),
    .txEstablish(txEstablish), .txEstablishAck(txEstablishAck), .rxMsg(rxMsg),
    .arrivalNotice());
  always #2 clk = ~clk;
  // --------------------------------
  // Tasks
  // --------------------------------
  // Compare under mask; an unknown never matches
  task automatic chk(input logic [11:0] seen, input logic [11:0] want,
    input logic [11:0] msk);
    begin
      cmp_count++;
      if (((seen ^ want) & msk) !== 12'h000)
      begin
        bad_count++;
        $display("Error at %0t: saw %h, expected %h", $time, seen, want);
      end
    end
  endtask
  task automatic note(input logic [11:0] v, input logic [11:0] m);
    expQ.push_back({v, m});
  endtask
  // One edge of user events and exchange command
  task automatic step(input logic [3:0] e, input logic [2:0] c);
    begin
      @(posedge clk);
      userEv <= e;
      exCmd <= c;
    end
  endtask
  // Idle, then wait bounded for all notes to be matched
  task automatic drain(input int lim);
    begin
      step(4'h0, 3'h0);
      for (i = 0; i < lim && expQ.size() > 0; i++)
        @(posedge clk);
      chk(12'(expQ.size()), 12'h000, 12'hfff);
      expQ.delete();
    end
  endtask
  // Ten-cycle reset with fresh configuration
  task automatic rst(input logic p, input logic r);
    begin
      if (reset_n)
        repeat (4) step(4'h0, 3'h0);
      aa = $random(seed);
      reset_n <= 1'h0;
      terminatingPriority <= p;
      ringOnEstablish <= r;
      autonomousAck <= aa[0];
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
    end
  endtask
  task automatic stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // --------------------------------
  // Monitor
  // --------------------------------
  // Any pulse or level/state change is an event; silent cycles are skipped
  always @(negedge clk)
  begin
    obs = {pathState, bearerTransparent, lineConditionSaved, txEstablish, txEstablishAck,
      txDisconnect, seizureAck, lineSignalOut, seqInit, disconnectHandoff};
    if (reset_n && ((|obs[6:0]) !== 1'h0 || obs[11:7] !== prevObs[11:7]))
    begin
      if (expQ.size() > 0)
      begin
        n = expQ.pop_front();
        chk(obs, n.v, n.m);
      end
      else
        chk(obs, ~obs, 12'hfff); // Unlooked-for event
    end
    prevObs = obs;
  end
  // Watchdog, well past the expected run length
  initial
  begin
    #20000;
    bad_count++;
    $display("Error at %0t: run timed out", $time);
    stop_test;
  end
  // --------------------------------
  // Scenarios
  // --------------------------------
  initial
  begin
    // Seizure, three retries, then accept
    rst(1'h0, 1'h0);
    note({PATH_BY_ACCESS, 9'h040}, 12'hff7);
    note({PATH_BY_ACCESS, 9'h040}, 12'hfff);
    note({PATH_BY_ACCESS, 9'h040}, 12'hfff);
    note({PATH_BY_ACCESS, 9'h040}, 12'hfff);
    step(4'h1, 3'h0);
    step(4'h4, 3'h0);
    drain(80);
    note({PATH_ACTIVE, 9'h102}, 12'hfff);
    step(4'h0, 3'h4);
    step(4'h0, 3'h2);
    drain(10);
    // Release, stray signals, condition, timeout
    rst(1'h0, 1'h0);
    note({PATH_BY_ACCESS, 9'h040}, 12'hff7);
    note({PATH_ABORT_REQ, 9'h000}, 12'hfff);
    note({PATH_ABORT_REQ, 9'h080}, 12'hfff);
    note({PATH_NULL, 9'h080}, 12'heff);
    note({PATH_NULL, 9'h000}, 12'heff);
    step(4'h1, 3'h0);
    step(4'h2, 3'h0);
    step(4'h4, 3'h0);
    step(4'h8, 3'h0);
    drain(60);
    // Reseize in abort, then late acknowledge
    rst(1'h0, 1'h0);
    note({PATH_BY_ACCESS, 9'h040}, 12'hff7);
    note({PATH_ABORT_REQ, 9'h000}, 12'hfff);
    note({PATH_BY_ACCESS, 5'h00, aa[0], 3'h0}, 12'hfff);
    note({PATH_ABORT_REQ, 9'h000}, 12'hfff);
    note({PATH_DISC, 9'h010}, 12'hefe);
    step(4'h1, 3'h0);
    step(4'h0, 3'h0);
    step(4'h2, 3'h0);
    step(4'h1, 3'h0);
    step(4'h2, 3'h0);
    step(4'h0, 3'h2);
    drain(30);
    // Exchange-started path, frozen seizure ignored
    for (int r = 0; r < 2; r++)
    begin
      rst(1'h0, r[0]);
      @(posedge clk);
      clkEnable <= 1'h0;
      userEv <= 4'h1;
      @(posedge clk);
      clkEnable <= 1'h1;
      userEv <= 4'h0;
      note({PATH_ACTIVE, 3'h0, 1'h1, 2'h0, r[0], 2'h0}, 12'hefd);
      step(4'h0, 3'h1);
      drain(20);
    end
    // Collision under both priorities
    for (int p = 0; p < 2; p++)
    begin
      rst(p[0], 1'h0);
      note({PATH_BY_ACCESS, 9'h040}, 12'hff7);
      if (p == 1)
        note({PATH_ACTIVE, 9'h120}, 12'hffd);
      else
        note({PATH_DISC, 9'h001}, 12'heff);
      step(4'h1, 3'h0);
      repeat (3) step(4'h0, 3'h0);
      step(4'h0, 3'h1);
      repeat (3) step(4'h0, 3'h0);
      step(4'h0, (p == 1) ? 3'h0 : 3'h3);
      drain(30);
    end
    stop_test;
  end
endmodule // pstn_path_setup_fsm_tb
